// *** hw/swe_regs.svh ***
// Purpose: Constants for the SPI status byte and write-enable latch block
// Assumes: Included by bare name; definitions only
// Notes:   Bit positions refer to the 8-bit status byte
`ifndef SWE_REGS_SVH
`define SWE_REGS_SVH

`define SWE_OP_SET_WRITE_LATCH_CMD      8'h06
`define SWE_OP_CLEAR_WRITE_LATCH_CMD      8'h04
`define SWE_OP_STATUS_READ_CMD      8'h05
`define SWE_OP_STATUS_WRITE_CMD      8'h01
`define SWE_OP_WRITE     8'h02

`define SWE_BIT_RSVD     7
`define SWE_BIT_ASE      6
`define SWE_BIT_PRO      5
`define SWE_BIT_SWF      4
`define SWE_BIT_BP_HI    3
`define SWE_BIT_BP_LO    2
`define SWE_BIT_WEL      1
`define SWE_BIT_BUSY     0

`define SWE_ASE_RST      1'h0
`define SWE_PRO_RST      1'h0
`define SWE_BP_RST       2'h0
`define SWE_BP_NONE      2'h0
`define SWE_BP_QUARTER   2'h1
`define SWE_BP_HALF      2'h2
`define SWE_BP_ALL       2'h3
`define SWE_PROT_QUARTER 13'h1800
`define SWE_PROT_HALF    13'h1000

`define SWE_ADDR_W       13
`define SWE_PAGE_BITS    5

`endif

// *** hw/swe_pkg.sv ***
// Purpose: Types shared by the status and write-enable block
// Assumes: Nothing
// Notes:   Command phase of one select period
package swe_pkg;
   typedef enum logic [2:0] {
      ST_OPCODE  = 3'b000,
      ST_SET_WRITE_LATCH_CMD    = 3'b001,
      ST_STAT_RD = 3'b010,
      ST_STAT_WR = 3'b011,
      ST_ADDR    = 3'b100,
      ST_ARR_DAT = 3'b101,
      ST_IGNORE  = 3'b110
   } swe_state_t;
endpackage

// *** hw/swe_sync.sv ***
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to i_ref_clk
// Notes:   Output holds the reset value while i_nrst is low
`timescale 1ns/100ps
module swe_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_nrst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta   <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule

// *** hw/swe_ctrl.sv ***
// Purpose: Status byte and write-enable latch of a serial SRAM, reached by SPI opcodes
// Assumes: SPI pins oversampled by i_ref_clk, serial clock far below half its rate
// Notes:   Modes 0 and 3; array writes leave as one-cycle strobes
`timescale 1ns/100ps
`include "swe_regs.svh"
module swe_ctrl
   import swe_pkg::*;
(
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_nrst,
   input  wire logic                   i_spi_clk,
   input  wire logic                   i_cs_n,
   input  wire logic                   i_mosi,
   input  wire logic                   i_hold_n,
   input  wire logic                   i_xfer_busy,
   input  wire logic                   i_secure_fail_set,
   input  wire logic                   i_secure_fail_clr,
   input  wire logic                   i_nv_load,
   input  wire logic [3:0]             i_nv_bits,
   output logic                        o_miso,
   output logic                        o_miso_oe,
   output logic                        o_arr_wr,
   output logic [`SWE_ADDR_W-1:0]      o_arr_addr,
   output logic [7:0]                  o_arr_data,
   output logic                        o_write_enable_latch,
   output logic                        o_autosave_disable,
   output logic                        o_page_wrap_select,
   output logic [1:0]                  o_protect_level,
   output logic                        o_secure_write_fail_flag
);
   localparam int AW = `SWE_ADDR_W;
   localparam int PB = `SWE_PAGE_BITS;

   function automatic logic prot_hit(input logic [1:0] lvl, input logic [AW-1:0] a);
      logic hit;
      hit = 1'b0;
      unique case (lvl)
         `SWE_BP_NONE:    hit = 1'b0;
         `SWE_BP_QUARTER: hit = (a >= `SWE_PROT_QUARTER);
         `SWE_BP_HALF:    hit = (a >= `SWE_PROT_HALF);
         `SWE_BP_ALL:     hit = 1'b1;
      endcase
      return hit;
   endfunction

   function automatic logic [AW-1:0] addr_step(input logic wrap_off, input logic [AW-1:0] a);
      logic [AW-1:0] n;
      n = a + {{(AW-1){1'b0}}, 1'b1};
      if (!wrap_off) begin
         n = {a[AW-1:PB], n[PB-1:0]};
      end
      return n;
   endfunction

   // Pin synchronisers: order sck, cs_n, mosi, hold_n
   logic [3:0]    pins_s;
   logic          sck_s;
   logic          cs_n_s;
   logic          mosi_s;
   logic          hold_n_s;
   logic          sck_d;
   logic          cs_n_d;
   logic          hold_act;
   swe_state_t    state;
   swe_state_t    next_state;
   logic [2:0]    bit_cnt;
   logic [6:0]    rx_shift;
   logic [6:0]    tx_shift;
   logic          tx_live;
   logic          addr_lo;
   logic [AW-1:0] addr;

   swe_sync #(
      .W       (4),
      .RST_VAL (4'h5)
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_async   ({i_spi_clk, i_cs_n, i_mosi, i_hold_n}),
      .o_sync    (pins_s)
   );

   assign sck_s    = pins_s[3];
   assign cs_n_s   = pins_s[2];
   assign mosi_s   = pins_s[1];
   assign hold_n_s = pins_s[0];

   wire       cs_rise   = cs_n_s & ~cs_n_d;
   wire       sck_rise  = ~cs_n_s & ~hold_act & sck_s & ~sck_d;
   wire       sck_fall  = ~cs_n_s & ~hold_act & ~sck_s & sck_d;
   wire       byte_done = sck_rise & (bit_cnt == 3'h7);
   wire [7:0] rx_byte   = {rx_shift, mosi_s};
   wire [7:0] status_byte = {1'b0, o_autosave_disable, o_page_wrap_select, o_secure_write_fail_flag,
                             o_protect_level, o_write_enable_latch, i_xfer_busy};
   wire       op_byte   = byte_done & (state == ST_OPCODE);
   wire       busy_skip = op_byte & i_xfer_busy & (rx_byte != `SWE_OP_STATUS_READ_CMD);
   wire       sr_write  = byte_done & (state == ST_STAT_WR);
   wire       arr_byte  = byte_done & (state == ST_ARR_DAT);
   wire       arr_prot  = arr_byte & prot_hit(o_protect_level, addr);
   wire       set_write_latch_cmd_done = cs_rise & ~hold_act & (state == ST_SET_WRITE_LATCH_CMD) & (bit_cnt == 3'h0);
   wire       clear_write_latch_cmd_hit  = op_byte & ~busy_skip & (rx_byte == `SWE_OP_CLEAR_WRITE_LATCH_CMD);
   wire       arr_end   = cs_rise & ((state == ST_ADDR) | (state == ST_ARR_DAT));
   wire       wel_clr   = clear_write_latch_cmd_hit | sr_write | arr_prot | arr_end | (cs_rise & hold_act);
   wire       tx_load   = sck_fall & (state == ST_STAT_RD) & (bit_cnt == 3'h0);
   wire       next_oe   = ~cs_n_s & ~hold_act & (state == ST_STAT_RD) & (tx_live | tx_load);

   always_comb begin
      next_state = state;
      if (byte_done) begin
         unique case (state)
            ST_OPCODE: begin
               if (busy_skip) begin
                  next_state = ST_IGNORE;
               end else begin
                  unique case (rx_byte)
                     `SWE_OP_SET_WRITE_LATCH_CMD:  next_state = ST_SET_WRITE_LATCH_CMD;
                     `SWE_OP_STATUS_READ_CMD:  next_state = ST_STAT_RD;
                     `SWE_OP_STATUS_WRITE_CMD:  next_state = o_write_enable_latch ? ST_STAT_WR : ST_IGNORE;
                     `SWE_OP_WRITE: next_state = o_write_enable_latch ? ST_ADDR : ST_IGNORE;
                     default:       next_state = ST_IGNORE;
                  endcase
               end
            end
            ST_SET_WRITE_LATCH_CMD:    next_state = ST_IGNORE;
            ST_STAT_RD: next_state = ST_STAT_RD;
            ST_STAT_WR: next_state = ST_IGNORE;
            ST_ADDR:    next_state = addr_lo ? ST_ARR_DAT : ST_ADDR;
            ST_ARR_DAT: next_state = ST_ARR_DAT;
            ST_IGNORE:  next_state = ST_IGNORE;
         endcase
      end
   end

   // Pause enters, and short of deselect leaves, only while the serial clock is low
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sck_d    <= 1'b0;
         cs_n_d   <= 1'b1;
         hold_act <= 1'b0;
      end else begin
         sck_d    <= sck_s;
         cs_n_d   <= cs_n_s;
         hold_act <= ~cs_n_s & (sck_s ? hold_act : ~hold_n_s);
      end
   end

   // Deselect returns the shifter to the opcode phase with no wait
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state    <= ST_OPCODE;
         bit_cnt  <= 3'h0;
         rx_shift <= 7'h00;
      end else if (cs_n_s) begin
         state    <= ST_OPCODE;
         bit_cnt  <= 3'h0;
      end else if (sck_rise) begin
         state    <= next_state;
         bit_cnt  <= bit_cnt + 3'h1;
         rx_shift <= rx_byte[6:0];
      end
   end

   // Status byte is resampled at each byte boundary
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_miso    <= 1'b0;
         o_miso_oe <= 1'b0;
         tx_shift  <= 7'h00;
         tx_live   <= 1'b0;
      end else begin
         o_miso_oe <= next_oe;
         if (cs_n_s) begin
            tx_live <= 1'b0;
         end else if (tx_load) begin
            o_miso   <= status_byte[7];
            tx_shift <= status_byte[6:0];
            tx_live  <= 1'b1;
         end else if (sck_fall && tx_live) begin
            o_miso   <= tx_shift[6];
            tx_shift <= {tx_shift[5:0], 1'b0};
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_write_enable_latch <= 1'b0;
      end else if (set_write_latch_cmd_done) begin
         o_write_enable_latch <= 1'b1;
      end else if (wel_clr) begin
         o_write_enable_latch <= 1'b0;
      end
   end

   // Retained bits take their saved copy on restore unless a status write lands that cycle; write also clears the latch
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_autosave_disable <= `SWE_ASE_RST;
         o_page_wrap_select <= `SWE_PRO_RST;
         o_protect_level    <= `SWE_BP_RST;
      end else if (sr_write) begin
         o_autosave_disable <= rx_byte[`SWE_BIT_ASE];
         o_page_wrap_select <= rx_byte[`SWE_BIT_PRO];
         o_protect_level    <= rx_byte[`SWE_BIT_BP_HI:`SWE_BIT_BP_LO];
      end else if (i_nv_load) begin
         {o_autosave_disable, o_page_wrap_select, o_protect_level} <= i_nv_bits;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_secure_write_fail_flag <= 1'b0;
      end else if (i_secure_fail_set) begin
         o_secure_write_fail_flag <= 1'b1;
      end else if (i_secure_fail_clr) begin
         o_secure_write_fail_flag <= 1'b0;
      end
   end

   // Address is high byte then low byte; pointer steps per data byte
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         addr       <= '0;
         addr_lo    <= 1'b0;
         o_arr_wr   <= 1'b0;
         o_arr_addr <= '0;
         o_arr_data <= 8'h00;
      end else begin
         o_arr_wr <= 1'b0;
         if (cs_n_s) begin
            addr_lo <= 1'b0;
         end else if (byte_done && state == ST_ADDR) begin
            addr_lo <= 1'b1;
            if (addr_lo) begin
               addr[7:0] <= rx_byte;
            end else begin
               addr[AW-1:8] <= rx_byte[AW-9:0];
            end
         end else if (arr_byte) begin
            addr <= addr_step(o_page_wrap_select, addr);
            if (!arr_prot) begin
               o_arr_wr   <= 1'b1;
               o_arr_addr <= addr;
               o_arr_data <= rx_byte;
            end
         end
      end
   end

   sequence s_set_write_latch_cmd_deselect;
      cs_rise && !hold_act && state == ST_SET_WRITE_LATCH_CMD && bit_cnt == 3'h0;
   endsequence

   sequence s_sr_write_byte;
      byte_done && state == ST_STAT_WR;
   endsequence

   property p_set_write_latch_cmd_sets;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      s_set_write_latch_cmd_deselect |=> o_write_enable_latch ##1 (status_byte[`SWE_BIT_WEL] || cs_n_d == 1'b0);
   endproperty
   a_set_write_latch_cmd_sets: assert property (p_set_write_latch_cmd_sets) else $error("latch not set after lone enable");
   property p_clear_write_latch_cmd_clears;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      op_byte && !i_xfer_busy && rx_byte == `SWE_OP_CLEAR_WRITE_LATCH_CMD |=> !o_write_enable_latch;
   endproperty
   a_clear_write_latch_cmd_clears: assert property (p_clear_write_latch_cmd_clears) else $error("disable opcode left latch set");
   property p_refuse_unlatched;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      op_byte && !i_xfer_busy && !o_write_enable_latch &&
      (rx_byte == `SWE_OP_STATUS_WRITE_CMD || rx_byte == `SWE_OP_WRITE) |=> state == ST_IGNORE;
   endproperty
   a_refuse_unlatched: assert property (p_refuse_unlatched) else $error("write accepted without latch");
   property p_sr_write;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      s_sr_write_byte |=> !o_write_enable_latch && o_protect_level == $past(rx_byte[3:2]) &&
                          o_page_wrap_select == $past(rx_byte[5]) && state == ST_IGNORE;
   endproperty
   a_sr_write: assert property (p_sr_write) else $error("status write result wrong");
   property p_sr_keeps_ro;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      s_sr_write_byte and (!i_secure_fail_set && !i_secure_fail_clr) |=> $stable(o_secure_write_fail_flag);
   endproperty
   a_sr_keeps_ro: assert property (p_sr_keeps_ro) else $error("status write changed fail flag");
   property p_busy_ignore;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      op_byte && i_xfer_busy && rx_byte != `SWE_OP_STATUS_READ_CMD |=> state == ST_IGNORE [*1] ##1 !o_arr_wr;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("command run while busy");

   property p_prot_discard;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      arr_byte && prot_hit(o_protect_level, addr) |=> !o_arr_wr && !o_write_enable_latch;
   endproperty
   a_prot_discard: assert property (p_prot_discard) else $error("protected byte written");

   property p_hold_abort;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      cs_rise && hold_act |=> !o_write_enable_latch && state == ST_OPCODE;
   endproperty
   a_hold_abort: assert property (p_hold_abort) else $error("pause abort kept latch");

   property p_status_read_cmd_out;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      tx_load |=> o_miso == $past(status_byte[7]) && o_miso_oe;
   endproperty
   a_status_read_cmd_out: assert property (p_status_read_cmd_out) else $error("status byte not shifted out");

   property p_arr_end;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      cs_rise && state == ST_ARR_DAT |=> !o_write_enable_latch;
   endproperty
   a_arr_end: assert property (p_arr_end) else $error("latch kept after array write");
endmodule

// *** tb/swe_spi_master.sv ***
// Purpose: SPI master model driving the status block pins
// Assumes: Mode 0, serial clock period 125 ns, stands still outside frames
// Notes:   Released data line is inverted so no stale bit survives
`timescale 1ns/100ps
module swe_spi_master (
   output logic      o_sck,
   output logic      o_cs_n,
   output logic      o_mosi,
   output logic      o_hold_n,
   input  wire logic i_miso
);
   initial begin
      o_sck = 1'h0;
      o_cs_n = 1'h1;
      o_mosi = 1'h0;
      o_hold_n = 1'h1;
   end
   task sel();
      o_cs_n = 1'h0;
      #62.5;
   endtask
   task desel();
      #62.5 o_cs_n = 1'h1;
      o_hold_n = 1'h1;
      o_mosi = ~o_mosi;
      #125;
   endtask
   // One byte each way, MSB first, sampled on the rising edge
   task xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_mosi = tx[i];
         #62.5 o_sck = 1'h1;
         rx[i] = i_miso;
         #62.5 o_sck = 1'h0;
      end
   endtask
   // Pause entered while the serial clock is low
   task pause();
      #20 o_hold_n = 1'h0;
      #100;
   endtask
endmodule

// *** tb/test_spi_status_write_enable_control.sv ***
// Purpose: Self-checking bench for the status byte and write latch
// Assumes: Serial traffic from the master model, side pins at negedge
// Notes:   Expected status values are worked out by hand per step
`timescale 1ns/100ps
module test_spi_status_write_enable_control;
   logic        clk = 1'h0;
   logic        nrst = 1'h0;
   logic        busy = 1'h0;
   logic        fset = 1'h0;
   logic        fclr = 1'h0;
   logic        nvld = 1'h0;
   logic [3:0]  nvb = 4'h0;
   logic        sck, cs_n, mosi, hold_n, miso, wr, write_enable_latch, autosave_disable, page_wrap_select, sfail, oe;
   logic [12:0] addr;
   logic [7:0]  dat, rx, s;
   logic [1:0]  bp;
   logic [12:0] la = 13'h0;
   logic [7:0]  ld = 8'h0;
   wire  [15:0] pins = {9'h0, autosave_disable, page_wrap_select, sfail, bp, write_enable_latch, 1'h0};
   // Undriven serial out shows the inverse of its last bit
   wire         so = oe ? miso : ~miso;
   int          n_errors = 0;
   int          n_tests = 0;
   int          n_wr = 0;

   always #5 clk = ~clk;

   swe_spi_master swe_spi_master_inst (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi),
      .o_hold_n(hold_n), .i_miso(so));

   swe_ctrl swe_ctrl_inst (.i_ref_clk(clk), .i_nrst(nrst), .i_spi_clk(sck), .i_cs_n(cs_n),
      .i_mosi(mosi), .i_hold_n(hold_n), .i_xfer_busy(busy), .i_secure_fail_set(fset),
      .i_secure_fail_clr(fclr), .i_nv_load(nvld), .i_nv_bits(nvb), .o_miso(miso),
      .o_miso_oe(oe), .o_arr_wr(wr), .o_arr_addr(addr), .o_arr_data(dat),
      .o_write_enable_latch(write_enable_latch), .o_autosave_disable(autosave_disable), .o_page_wrap_select(page_wrap_select),
      .o_protect_level(bp), .o_secure_write_fail_flag(sfail));

   always @(negedge clk) begin
      if (wr === 1'h1) begin
         n_wr++;
         la <= addr;
         ld <= dat;
      end
   end

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cmd1(input logic [7:0] op);
      swe_spi_master_inst.sel();
      swe_spi_master_inst.xb(op, rx);
      swe_spi_master_inst.desel();
   endtask
   task set_write_latch_cmd();
      cmd1(8'h06);
   endtask
   task status_write_cmd(input logic [7:0] v);
      swe_spi_master_inst.sel();
      swe_spi_master_inst.xb(8'h01, rx);
      swe_spi_master_inst.xb(v, rx);
      swe_spi_master_inst.desel();
   endtask
   task status_read_cmd(output logic [7:0] v);
      swe_spi_master_inst.sel();
      swe_spi_master_inst.xb(8'h05, rx);
      swe_spi_master_inst.xb(8'hFF, v);
      swe_spi_master_inst.desel();
   endtask
   task awr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
      swe_spi_master_inst.sel();
      swe_spi_master_inst.xb(8'h02, rx);
      swe_spi_master_inst.xb(a[15:8], rx);
      swe_spi_master_inst.xb(a[7:0], rx);
      swe_spi_master_inst.xb(d0, rx);
      swe_spi_master_inst.xb(d1, rx);
      swe_spi_master_inst.desel();
   endtask
   task tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #500000;
      n_errors++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk) nrst = 1'h1;
      repeat (8) @(negedge clk);
      chk(pins, 16'h00);
      status_read_cmd(s);
      chk({8'h0, s}, 16'h00);
      chk({15'h0, oe}, 16'h0);
      status_write_cmd(8'h7C);
      chk(pins, 16'h00);
      set_write_latch_cmd();
      chk(pins, 16'h02);
      swe_spi_master_inst.sel();
      swe_spi_master_inst.xb(8'h05, rx);
      swe_spi_master_inst.xb(8'hFF, s);
      chk({8'h0, s}, 16'h02);
      @(negedge clk) busy = 1'h1;
      swe_spi_master_inst.xb(8'hFF, s);
      chk({8'h0, s}, 16'h03);
      swe_spi_master_inst.desel();
      cmd1(8'h04);
      chk(pins, 16'h02);
      @(negedge clk) busy = 1'h0;
      status_write_cmd(8'h7C);
      chk(pins, 16'h6C);
      set_write_latch_cmd();
      status_read_cmd(s);
      chk({8'h0, s}, 16'h6E);
      awr(16'h0000, 8'h12, 8'h34);
      chk(16'(n_wr), 16'h0);
      chk(pins, 16'h6C);
      set_write_latch_cmd();
      status_write_cmd(8'h00);
      chk(pins, 16'h00);
      set_write_latch_cmd();
      cmd1(8'h04);
      chk(pins, 16'h00);
      set_write_latch_cmd();
      status_write_cmd(8'h04);
      set_write_latch_cmd();
      awr(16'h001F, 8'hA5, 8'h5A);
      chk(16'(n_wr), 16'h2);
      chk({3'h0, la}, 16'h0000);
      chk({8'h0, ld}, 16'h5A);
      chk(pins, 16'h04);
      set_write_latch_cmd();
      status_write_cmd(8'h24);
      set_write_latch_cmd();
      awr(16'h17FF, 8'h11, 8'h22);
      chk(16'(n_wr), 16'h3);
      chk({3'h0, la}, 16'h17FF);
      chk({8'h0, ld}, 16'h11);
      chk(pins, 16'h24);
      set_write_latch_cmd();
      swe_spi_master_inst.sel();
      swe_spi_master_inst.xb(8'h05, rx);
      swe_spi_master_inst.pause();
      chk({15'h0, oe}, 16'h0);
      swe_spi_master_inst.desel();
      chk(pins, 16'h24);
      @(negedge clk) fset = 1'h1;
      @(negedge clk) fset = 1'h0;
      status_read_cmd(s);
      chk({8'h0, s}, 16'h34);
      set_write_latch_cmd();
      status_write_cmd(8'h00);
      chk(pins, 16'h10);
      @(negedge clk) fclr = 1'h1;
      @(negedge clk) fclr = 1'h0;
      chk(pins, 16'h00);
      nvb = 4'hA;
      @(negedge clk) nvld = 1'h1;
      @(negedge clk) nvld = 1'h0;
      @(negedge clk);
      chk(pins, 16'h48);
      tally_and_finish();
   end
endmodule
